// ===== hw/can_fd_timing_protocol_core.sv
// Bit timing, FD field handling, delay compensation and single-shot status of a CAN FD core.

// Function
// - Among matching filters prefer 32-bit scale, then list mode, then smaller number.
// - Time-triggered mode runs a 16-bit bit counter, stamped into each frame.
// - Retransmit forbid attempts each frame once; no retry on lost arbitration or error.
// - Single-shot end sets finished flag plus success, arbitration-lost or error bit.
// - Synchronisation segment of every nominal bit is exactly one quantum.
// - Valid edge: first dominant-to-recessive toggle per bit, not while sending recessive.
// - Edge in segment one lengthens it, in segment two shortens it, by at most jump width.
// - Quantum is 1+prescaler clocks; bit is 1 + (1+seg1) + (1+seg2) quanta.
// - FD enable cleared means classical frames only; set allows classical and FD.
// - Recessive FDF bit marks an FD frame, dominant marks classical.
// - Non-standard-format select chooses original or international FD frame format.
// - Recessive BRS switches to data timing up to CRC delimiter; dominant keeps nominal.
// - Exception handling enabled: recessive reserved bit abandons frame, idle at next sample.
// - Exception handling disabled: recessive reserved bit is a form error.
// - Any recessive reserved bit sets the protocol exception flag.
// - ESI sent from error state, or from mailbox when indicator mode set.
// - Transmitted BRS comes from the mailbox property bit; FDF is the mailbox bit gated by FD enable.
// - Secondary sample point is used only while delay compensation is enabled.
// - Compensation mode set: secondary sample delay is the software offset.
// - Compensation mode cleared: measure transmit-to-receive delay at FDF/res0 edge.
// - Delay is offset plus larger of measured value and filter value.
module can_fd_timing_protocol_core (
  input  wire logic                                    i_sys_clk,
  input  wire logic                                    i_rst_n,
  input  wire can_fd_core_pkg::timing_t                i_nominal_timing,
  input  wire can_fd_core_pkg::timing_t                i_data_timing,
  input  wire can_fd_core_pkg::fd_cfg_t                i_fd_cfg,
  input  wire can_fd_core_pkg::mode_t                  i_mode,
  input  wire can_fd_core_pkg::slot_t                  i_slot,
  input  wire can_fd_core_pkg::tx_prop_t               i_tx_prop,
  input  wire logic                                    i_error_passive,
  input  wire logic                                    i_tx_request,
  input  wire can_fd_core_pkg::tx_event_t              i_tx_event,
  input  wire logic                                    i_clear_exception,
  input  wire logic [can_fd_core_pkg::NFILT-1:0]       i_filter_match,
  input  wire logic [can_fd_core_pkg::NFILT-1:0]       i_filter_scale32,
  input  wire logic [can_fd_core_pkg::NFILT-1:0]       i_filter_list,
  input  wire logic                                    i_bus_receive_line,
  output logic                                         o_bus_transmit_line,
  output logic                                         o_sample_point,
  output logic                                         o_bit_start,
  output logic                                         o_rx_bit,
  output logic                                         o_fd_frame,
  output logic                                         o_data_phase,
  output logic                                         o_iso_format,
  output logic                                         o_protocol_exception,
  output logic                                         o_form_error,
  output logic                                         o_go_idle,
  output logic [can_fd_core_pkg::STAMP_W-1:0]          o_time_stamp,
  output logic [can_fd_core_pkg::STAMP_W-1:0]          o_frame_stamp,
  output can_fd_core_pkg::tx_status_t                  o_tx_status,
  output logic                                         o_retry,
  output logic [6:0]                                   o_delay_comp_measured,
  output logic [7:0]                                   o_ssp_delay,
  output logic                                         o_ssp_pulse,
  output logic                                         o_ssp_rx_bit,
  output logic                                         o_filter_hit,
  output logic [can_fd_core_pkg::FILT_IDX_W-1:0]       o_filter_index
);

  can_fd_core_pkg::core_st_t q;
  can_fd_core_pkg::core_st_t d;
  can_fd_core_pkg::timing_t  tm;
  logic       tick;
  logic       sp;
  logic       bs;
  logic       rx_new;
  logic       rx_rise;
  logic       rx_fall;
  logic       valid;
  logic       rsv;
  logic       tx;
  logic       tx_fall;
  logic       forbid;
  logic [7:0] sjw;
  logic [7:0] len;
  logic [7:0] err;
  logic [6:0] used;
  logic [1:0] best;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  always_comb begin
    d    = q;
    tm   = q.data_phase ? i_data_timing : i_nominal_timing;
    sp   = 1'b0;
    bs   = 1'b0;
    rsv  = 1'b0;
    tx   = can_fd_core_pkg::RECESSIVE;
    err  = '0;
    best = '0;
    d.sp        = 1'b0;
    d.bit_start = 1'b0;
    d.form_err  = 1'b0;
    d.go_idle   = 1'b0;
    d.retry     = 1'b0;
    d.ssp_pulse = 1'b0;

    // A pin change is accepted once the second and third stages agree.
    d.rx_sync = {q.rx_sync[1:0], i_bus_receive_line};
    rx_new    = (q.rx_sync[1] == q.rx_sync[2]) ? q.rx_sync[2] : q.rx;
    d.rx      = rx_new;
    rx_rise   = (q.rx == can_fd_core_pkg::DOMINANT) && (rx_new == can_fd_core_pkg::RECESSIVE);
    rx_fall   = (q.rx == can_fd_core_pkg::RECESSIVE) && (rx_new == can_fd_core_pkg::DOMINANT);
    valid     = rx_rise && !q.edge_seen &&
                !(i_slot.transmitting && q.tx_line == can_fd_core_pkg::RECESSIVE);
    if (rx_rise) begin
      d.edge_seen = 1'b1;
    end

    tick   = (q.qcnt >= tm.presc);
    d.qcnt = tick ? '0 : q.qcnt + can_fd_core_pkg::QCNT_ONE;
    sjw    = {1'b0, tm.sjw};
    len    = q.seg_len;

    case (q.seg)
      can_fd_core_pkg::SEG_SYNC: begin
        if (tick) begin
          d.seg     = can_fd_core_pkg::SEG_ONE;
          d.tq      = '0;
          d.seg_len = {1'b0, tm.seg1} + can_fd_core_pkg::TQ_ONE;
        end
      end
      can_fd_core_pkg::SEG_ONE: begin
        if (valid) begin
          err = q.tq + can_fd_core_pkg::TQ_ONE;
          len = q.seg_len + ((err < sjw) ? err : sjw);
        end
        d.seg_len = len;
        if (tick) begin
          if (q.tq + can_fd_core_pkg::TQ_ONE >= len) begin
            sp        = 1'b1;
            d.seg     = can_fd_core_pkg::SEG_TWO;
            d.tq      = '0;
            d.seg_len = {1'b0, tm.seg2} + can_fd_core_pkg::TQ_ONE;
          end else begin
            d.tq = q.tq + can_fd_core_pkg::TQ_ONE;
          end
        end
      end
      can_fd_core_pkg::SEG_TWO: begin
        err = q.seg_len - q.tq;
        if (valid && err <= sjw) begin
          // The edge closes this bit early and becomes the next bit's sync segment.
          bs     = 1'b1;
          d.qcnt = '0;
          d.seg  = can_fd_core_pkg::SEG_SYNC;
        end else begin
          if (valid) begin
            len = q.seg_len - sjw;
          end
          d.seg_len = len;
          if (tick) begin
            if (q.tq + can_fd_core_pkg::TQ_ONE >= len) begin
              bs    = 1'b1;
              d.seg = can_fd_core_pkg::SEG_SYNC;
            end else begin
              d.tq = q.tq + can_fd_core_pkg::TQ_ONE;
            end
          end
        end
      end
      default: begin
        d.seg = can_fd_core_pkg::SEG_SYNC;
      end
    endcase

    // -------------------------------------------------------------------------
    // Transmit point
    // -------------------------------------------------------------------------
    if (bs) begin
      d.bit_start = 1'b1;
      d.edge_seen = 1'b0;
      case (i_slot.field)
        can_fd_core_pkg::FLD_FDF: tx = i_fd_cfg.fd_enable & i_tx_prop.fdf;
        can_fd_core_pkg::FLD_BRS: tx = i_tx_prop.brs;
        can_fd_core_pkg::FLD_ESI: begin
          tx = i_fd_cfg.error_indicator_mode ? i_tx_prop.esi : i_error_passive;
        end
        default: tx = i_slot.tx_bit;
      endcase
      d.tx_line = i_slot.transmitting ? tx : can_fd_core_pkg::RECESSIVE;
      // Counting only inside the mode keeps stamps meaningful; wrap is silent.
      d.stamp = i_mode.time_triggered ? q.stamp + can_fd_core_pkg::STAMP_ONE : '0;
    end

    // -------------------------------------------------------------------------
    // Sample point and FD field decode
    // -------------------------------------------------------------------------
    if (i_clear_exception) begin
      d.pre = 1'b0;
    end
    if (sp) begin
      d.sp     = 1'b1;
      d.rx_bit = rx_new;
      if (q.exc_pend) begin
        d.go_idle    = 1'b1;
        d.exc_pend   = 1'b0;
        d.fd_frame   = 1'b0;
        d.data_phase = 1'b0;
      end
      case (i_slot.field)
        can_fd_core_pkg::FLD_SOF: begin
          d.frame_stamp = q.stamp;
          d.fd_frame    = 1'b0;
          d.data_phase  = 1'b0;
        end
        can_fd_core_pkg::FLD_FDF: begin
          d.fd_frame = i_fd_cfg.fd_enable && (rx_new == can_fd_core_pkg::RECESSIVE);
          rsv        = !i_fd_cfg.fd_enable && (rx_new == can_fd_core_pkg::RECESSIVE);
        end
        can_fd_core_pkg::FLD_RES: rsv = (rx_new == can_fd_core_pkg::RECESSIVE);
        can_fd_core_pkg::FLD_BRS: begin
          if (q.fd_frame && rx_new == can_fd_core_pkg::RECESSIVE) begin
            d.data_phase = 1'b1;
          end
        end
        can_fd_core_pkg::FLD_CRC_DELIM: d.data_phase = 1'b0;
        default: begin
        end
      endcase
      if (rsv) begin
        d.pre = 1'b1;
        if (i_fd_cfg.protocol_exception_disable) begin
          d.form_err = 1'b1;
        end else begin
          d.exc_pend = 1'b1;
        end
      end
    end
    d.iso = !i_fd_cfg.non_standard_format_select;

    // -------------------------------------------------------------------------
    // Transmitter delay compensation
    // -------------------------------------------------------------------------
    tx_fall = bs && q.tx_line == can_fd_core_pkg::RECESSIVE && d.tx_line == can_fd_core_pkg::DOMINANT;
    if (tx_fall) begin
      d.ssp_cnt = '0;
    end else if (q.ssp_cnt != can_fd_core_pkg::SSP_MAX) begin
      d.ssp_cnt = q.ssp_cnt + can_fd_core_pkg::TQ_ONE;
    end
    if (tx_fall && i_slot.field == can_fd_core_pkg::FLD_RES && i_slot.transmitting &&
        i_fd_cfg.delay_comp_enable && !i_fd_cfg.delay_comp_mode) begin
      d.measuring = 1'b1;
      d.meas_cnt  = '0;
    end else if (q.measuring) begin
      if (rx_fall) begin
        d.meas      = q.meas_cnt;
        d.measuring = 1'b0;
      end else if (q.meas_cnt != can_fd_core_pkg::MEAS_MAX) begin
        d.meas_cnt = q.meas_cnt + can_fd_core_pkg::MEAS_ONE;
      end
    end
    // A glitch can cut the measurement short, so the filter value acts as a floor.
    used        = (q.meas > i_fd_cfg.delay_comp_filter) ? q.meas : i_fd_cfg.delay_comp_filter;
    d.ssp_delay = {1'b0, i_fd_cfg.delay_comp_offset} +
                  (i_fd_cfg.delay_comp_mode ? 8'h00 : {1'b0, used});
    if (i_fd_cfg.delay_comp_enable && q.data_phase && i_slot.transmitting &&
        q.ssp_cnt == q.ssp_delay) begin
      d.ssp_pulse = 1'b1;
      d.ssp_bit   = rx_new;
    end

    // -------------------------------------------------------------------------
    // Single-shot transmit status
    // -------------------------------------------------------------------------
    forbid = i_mode.retransmit_forbid | i_mode.time_triggered;
    if (i_tx_request) begin
      d.txs = '0;
    end
    if (i_tx_event.ok) begin
      d.txs.mailbox_tx_finished = 1'b1;
      d.txs.mailbox_tx_ok       = 1'b1;
    end else if (i_tx_event.arb_lost || i_tx_event.bus_error) begin
      if (forbid) begin
        d.txs.mailbox_tx_finished      = 1'b1;
        d.txs.mailbox_arbitration_lost = i_tx_event.arb_lost;
        d.txs.mailbox_tx_error         = i_tx_event.bus_error;
      end else begin
        d.retry = 1'b1;
      end
    end

    // -------------------------------------------------------------------------
    // Acceptance filter priority
    // -------------------------------------------------------------------------
    d.filt_hit = 1'b0;
    d.filt_idx = '0;
    for (int i = can_fd_core_pkg::NFILT - 1; i >= 0; i--) begin
      // Walking downward with >= lets the smaller number win a tie.
      if (i_filter_match[i] && (!d.filt_hit || {i_filter_scale32[i], i_filter_list[i]} >= best)) begin
        d.filt_hit = 1'b1;
        d.filt_idx = can_fd_core_pkg::FILT_IDX_W'(i);
        best       = {i_filter_scale32[i], i_filter_list[i]};
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q         <= '0;
      q.tx_line <= can_fd_core_pkg::RECESSIVE;
      q.rx      <= can_fd_core_pkg::RECESSIVE;
      q.rx_sync <= can_fd_core_pkg::SYNC_RESET;
    end else begin
      q <= d;
    end
  end

  assign o_bus_transmit_line   = q.tx_line;
  assign o_sample_point        = q.sp;
  assign o_bit_start           = q.bit_start;
  assign o_rx_bit              = q.rx_bit;
  assign o_fd_frame            = q.fd_frame;
  assign o_data_phase          = q.data_phase;
  assign o_iso_format          = q.iso;
  assign o_protocol_exception  = q.pre;
  assign o_form_error          = q.form_err;
  assign o_go_idle             = q.go_idle;
  assign o_time_stamp          = q.stamp;
  assign o_frame_stamp         = q.frame_stamp;
  assign o_tx_status           = q.txs;
  assign o_retry               = q.retry;
  assign o_delay_comp_measured = q.meas;
  assign o_ssp_delay           = q.ssp_delay;
  assign o_ssp_pulse           = q.ssp_pulse;
  assign o_ssp_rx_bit          = q.ssp_bit;
  assign o_filter_hit          = q.filt_hit;
  assign o_filter_index        = q.filt_idx;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  chk_single_shot_end: assert property (
    (i_mode.retransmit_forbid && !i_tx_event.ok && i_tx_event.arb_lost) |=>
      o_tx_status.mailbox_tx_finished && o_tx_status.mailbox_arbitration_lost && !o_retry)
    else $error("single-shot loss did not finish the mailbox");
  chk_retry_allowed: assert property (
    (!i_mode.retransmit_forbid && !i_mode.time_triggered && !i_tx_event.ok && i_tx_event.bus_error) |=> o_retry)
    else $error("retry missing with retransmission allowed");
  chk_sync_one_tq: assert property (
    (q.seg == can_fd_core_pkg::SEG_SYNC && tick) |=> q.seg == can_fd_core_pkg::SEG_ONE)
    else $error("sync segment longer than one quantum");
  chk_stamp_step: assert property (
    (o_bit_start && i_mode.time_triggered && $past(i_mode.time_triggered)) |->
      o_time_stamp == $past(o_time_stamp) + can_fd_core_pkg::STAMP_ONE)
    else $error("time stamp did not step by one per bit");
  chk_classic_only: assert property (
    (sp && i_slot.field == can_fd_core_pkg::FLD_FDF && !i_fd_cfg.fd_enable) |=> !o_fd_frame)
    else $error("FD frame flagged with FD disabled");
  chk_exception_flag: assert property (
    (sp && rsv) |=> o_protocol_exception)
    else $error("exception flag not set");
  chk_form_error: assert property (
    (sp && rsv && i_fd_cfg.protocol_exception_disable) |=> o_form_error && !o_go_idle)
    else $error("form error missing for recessive reserved bit");
  chk_idle_later: assert property (
    (sp && rsv && !i_fd_cfg.protocol_exception_disable) |=> !o_form_error && q.exc_pend)
    else $error("exception handling did not defer to next sample point");
  chk_brs_switch: assert property (
    (sp && i_slot.field == can_fd_core_pkg::FLD_BRS && o_fd_frame && rx_new && !q.exc_pend) |=> o_data_phase)
    else $error("data phase not entered on recessive BRS");
  chk_ssp_offset: assert property (
    i_fd_cfg.delay_comp_mode |=> o_ssp_delay == {1'b0, $past(i_fd_cfg.delay_comp_offset)})
    else $error("manual delay differs from offset");

  cov_fd_frame: cover property (o_fd_frame ##[1:1000] o_data_phase);
  cov_resync: cover property (valid && q.seg == can_fd_core_pkg::SEG_TWO);
  cov_measure: cover property (q.measuring ##1 !q.measuring);

endmodule : can_fd_timing_protocol_core

// ===== hw/can_fd_core_pkg.sv
// Types and constants shared by the CAN FD protocol timing core.
package can_fd_core_pkg;

  localparam int unsigned NFILT      = 8;
  localparam int unsigned FILT_IDX_W = 3;
  localparam int unsigned STAMP_W    = 16;

  localparam logic RECESSIVE = 1'b1;
  localparam logic DOMINANT  = 1'b0;

  localparam logic [9:0]  QCNT_ONE   = 10'h001;
  localparam logic [7:0]  TQ_ONE     = 8'h01;
  localparam logic [7:0]  SSP_MAX    = 8'hff;
  localparam logic [6:0]  MEAS_MAX   = 7'h7f;
  localparam logic [6:0]  MEAS_ONE   = 7'h01;
  localparam logic [15:0] STAMP_ONE  = 16'h0001;
  localparam logic [2:0]  SYNC_RESET = 3'h7;

  // Segment fields hold length minus one, as software writes them.
  typedef struct packed {
    logic [9:0] presc;
    logic [6:0] seg1;
    logic [6:0] seg2;
    logic [6:0] sjw;
  } timing_t;

  typedef struct packed {
    logic       fd_enable;
    logic       non_standard_format_select;
    logic       protocol_exception_disable;
    logic       error_indicator_mode;
    logic       delay_comp_enable;
    logic       delay_comp_mode;
    logic [6:0] delay_comp_offset;
    logic [6:0] delay_comp_filter;
  } fd_cfg_t;

  typedef struct packed {
    logic time_triggered;
    logic retransmit_forbid;
  } mode_t;

  typedef enum logic [3:0] {
    FLD_IDLE      = 4'h0,
    FLD_SOF       = 4'h1,
    FLD_ARB       = 4'h2,
    FLD_FDF       = 4'h3,
    FLD_RES       = 4'h4,
    FLD_BRS       = 4'h5,
    FLD_ESI       = 4'h6,
    FLD_DATA      = 4'h7,
    FLD_CRC_DELIM = 4'h8,
    FLD_OTHER     = 4'h9
  } field_t;

  typedef struct packed {
    field_t field;
    logic   tx_bit;
    logic   transmitting;
  } slot_t;

  typedef struct packed {
    logic fdf;
    logic brs;
    logic esi;
  } tx_prop_t;

  typedef struct packed {
    logic ok;
    logic arb_lost;
    logic bus_error;
  } tx_event_t;

  typedef struct packed {
    logic mailbox_tx_finished;
    logic mailbox_tx_ok;
    logic mailbox_arbitration_lost;
    logic mailbox_tx_error;
  } tx_status_t;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'h0,
    SEG_ONE  = 2'h1,
    SEG_TWO  = 2'h2
  } bitseg_t;

  typedef struct packed {
    logic [2:0]            rx_sync;
    logic                  rx;
    logic [9:0]            qcnt;
    logic [7:0]            tq;
    logic [7:0]            seg_len;
    bitseg_t               seg;
    logic                  edge_seen;
    logic                  tx_line;
    logic                  sp;
    logic                  bit_start;
    logic                  rx_bit;
    logic                  fd_frame;
    logic                  data_phase;
    logic                  iso;
    logic                  pre;
    logic                  exc_pend;
    logic                  form_err;
    logic                  go_idle;
    logic [STAMP_W-1:0]    stamp;
    logic [STAMP_W-1:0]    frame_stamp;
    tx_status_t            txs;
    logic                  retry;
    logic                  measuring;
    logic [6:0]            meas_cnt;
    logic [6:0]            meas;
    logic [7:0]            ssp_cnt;
    logic [7:0]            ssp_delay;
    logic                  ssp_pulse;
    logic                  ssp_bit;
    logic                  filt_hit;
    logic [FILT_IDX_W-1:0] filt_idx;
  } core_st_t;

endpackage : can_fd_core_pkg

// ===== testbench/can_bus_partner.sv
// Transceiver and bus model that loops the transmit line back after a delay.
module can_bus_partner #(
  parameter int unsigned DELAY = 4
) (
  input  wire logic i_sys_clk,
  input  wire logic i_tx,
  output logic      o_rx
);
  timeunit 1ns;
  timeprecision 100ps;
  // The bus idles recessive, so the pipe starts filled with ones.
  logic [DELAY-1:0] dly_q = '1;
  always_ff @(posedge i_sys_clk) begin
    dly_q <= {dly_q[DELAY-2:0], i_tx};
  end
  assign o_rx = dly_q[DELAY-1];
endmodule : can_bus_partner

// ===== testbench/testbench.sv
// Self-checking bench for the CAN FD protocol timing core.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic                       sys_clk = 1'b0;
  logic                       rst_n = 1'b0;
  can_fd_core_pkg::timing_t   nom = '{10'h000, 7'h00, 7'h00, 7'h00};
  can_fd_core_pkg::fd_cfg_t   cfg = '0;
  can_fd_core_pkg::mode_t     mode = '0;
  can_fd_core_pkg::slot_t     slot = '{can_fd_core_pkg::FLD_IDLE, 1'b1, 1'b0};
  can_fd_core_pkg::tx_prop_t  prop = '0;
  can_fd_core_pkg::tx_event_t tev = '0;
  can_fd_core_pkg::tx_status_t txs;
  logic                       ep = 1'b0;
  logic                       treq = 1'b0;
  logic                       clrx = 1'b0;
  logic [7:0]                 fm = '0;
  logic [7:0]                 fs = '0;
  logic [7:0]                 fl = '0;
  logic                       rx, tx, sp, bs, fd, pe, fe, gi, retry, fhit, iso;
  logic [7:0]                 sspd;
  logic [2:0]                 fidx;
  logic [15:0]                ts, ts0;
  logic [27:0]                ft [4] = '{{8'h0c, 8'h08, 8'h00, 4'hb}, {8'h06, 8'h00, 8'h04, 4'ha},
                                         {8'h03, 8'h02, 8'h01, 4'h9}, {8'h30, 8'h30, 8'h20, 4'hd}};
  int                         miscompares = 0;
  int                         n_tests = 0;
  int                         n;
  always #2.5 sys_clk = ~sys_clk;
  can_bus_partner #(.DELAY(4)) bus (.i_sys_clk(sys_clk), .i_tx(tx), .o_rx(rx));
  can_fd_timing_protocol_core DUT (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_nominal_timing(nom), .i_data_timing(nom), .i_fd_cfg(cfg),
    .i_mode(mode), .i_slot(slot), .i_tx_prop(prop), .i_error_passive(ep), .i_tx_request(treq),
    .i_tx_event(tev), .i_clear_exception(clrx), .i_filter_match(fm), .i_filter_scale32(fs),
    .i_filter_list(fl), .i_bus_receive_line(rx), .o_bus_transmit_line(tx), .o_sample_point(sp),
    .o_bit_start(bs), .o_rx_bit(), .o_fd_frame(fd), .o_data_phase(), .o_iso_format(iso),
    .o_protocol_exception(pe), .o_form_error(fe), .o_go_idle(gi), .o_time_stamp(ts), .o_frame_stamp(),
    .o_tx_status(txs), .o_retry(retry), .o_delay_comp_measured(), .o_ssp_delay(sspd), .o_ssp_pulse(),
    .o_ssp_rx_bit(), .o_filter_hit(fhit), .o_filter_index(fidx));

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Sel 0 waits for a bit start, 1 for a sample point; a hang ends the run.
  task automatic wait_for(input int sel);
    int cnt;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      #1;
      cnt++;
      if (cnt > 5000) begin
        miscompares++;
        $display("[ERR] %0t wait timed out", $time);
        test_done();
      end
    end while (((sel == 0) ? bs : sp) !== 1'b1);
  endtask : wait_for

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) nom <= i ? {10'h001, 7'h02, 7'h01, 7'h01} : {10'h000, 7'h00, 7'h00, 7'h00};
      wait_for(0);
      wait_for(0);
      n = 0;
      do begin @(posedge sys_clk); #1; n++; end while (bs !== 1'b1 && n < 99);
      chk(16'(n), i ? 16'h000c : 16'h0003, "bit length");
    end
    $display("bit timing test done");
    @(posedge sys_clk) mode.time_triggered <= 1'b1;
    wait_for(0);
    for (int i = 0; i < 3; i++) begin
      ts0 = ts;
      wait_for(0);
      chk(ts, ts0 + 16'h0001, "stamp step");
    end
    $display("time stamp test done");
    @(posedge sys_clk) mode <= 2'b01;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) tev <= 3'b100 >> i;
      @(posedge sys_clk) tev <= '0;
      #1 chk({retry, txs}, {2'b01, 3'b100 >> i}, "single shot");
      @(posedge sys_clk) treq <= 1'b1;
      @(posedge sys_clk) treq <= 1'b0;
    end
    @(posedge sys_clk) begin mode <= '0; tev <= 3'b010; end
    @(posedge sys_clk) tev <= '0;
    #1 chk(retry, 1'b1, "retry");
    $display("transmit status test done");
    foreach (ft[i]) begin
      @(posedge sys_clk) {fm, fs, fl} <= ft[i][27:4];
      @(posedge sys_clk);
      #1 chk({fhit, fidx}, ft[i][3:0], "filter winner");
    end
    $display("filter test done");
    @(posedge sys_clk) begin
      cfg.delay_comp_mode <= 1'b1;
      cfg.delay_comp_offset <= 7'h05;
      cfg.delay_comp_filter <= 7'h20;
      cfg.non_standard_format_select <= 1'b1;
    end
    @(posedge sys_clk) cfg.delay_comp_mode <= 1'b0;
    #1 chk({iso, sspd}, 9'h005, "manual delay");
    @(posedge sys_clk);
    #1 chk(sspd, 8'h25, "filter floor");
    $display("delay compensation test done");
    wait_for(1);
    @(posedge sys_clk) begin slot <= '{can_fd_core_pkg::FLD_FDF, 1'b1, 1'b0}; cfg.fd_enable <= 1'b1; end
    wait_for(1);
    chk(fd, 1'b1, "fd frame");
    @(posedge sys_clk) begin slot.field <= can_fd_core_pkg::FLD_RES; cfg.protocol_exception_disable <= 1'b1; end
    wait_for(1);
    chk({pe, fe}, 2'b11, "form error");
    @(posedge sys_clk) begin slot.field <= can_fd_core_pkg::FLD_OTHER; clrx <= 1'b1; end
    @(posedge sys_clk) begin clrx <= 1'b0; cfg.protocol_exception_disable <= 1'b0; end
    #1 chk(pe, 1'b0, "exception cleared");
    wait_for(1);
    @(posedge sys_clk) slot.field <= can_fd_core_pkg::FLD_RES;
    wait_for(1);
    chk({pe, fe}, 2'b10, "exception flag");
    @(posedge sys_clk) slot.field <= can_fd_core_pkg::FLD_OTHER;
    wait_for(1);
    chk(gi, 1'b1, "go idle");
    @(posedge sys_clk) begin slot.field <= can_fd_core_pkg::FLD_FDF; cfg.fd_enable <= 1'b0; clrx <= 1'b1; end
    @(posedge sys_clk) clrx <= 1'b0;
    wait_for(1);
    chk({fd, pe}, 2'b01, "fdf refused");
    $display("exception test done");
    for (int i = 0; i < 4; i++) begin
      wait_for(1);
      @(posedge sys_clk) begin
        slot <= '{can_fd_core_pkg::FLD_ESI, 1'b0, 1'b1};
        cfg.error_indicator_mode <= i[1];
        ep <= i[0];
        prop.esi <= ~i[0];
      end
      wait_for(0);
      chk(tx, i[1] ? !i[0] : i[0], "esi level");
    end
    $display("error indicator test done");
    test_done();
  end
endmodule : testbench
